// >>> design/pli_pulse_latch_inputs.v
// pulse latch inputs: fast capture of eight terminals behind wishbone
`timescale 1ns/1ps
`include "pli_consts.vh"
module pli_pulse_latch_inputs #(
	parameter NUM_NORMAL = 6
) (
	input  wire                  clk_i,
	input  wire                  rst_i,
	input  wire                  wb_cyc_i,
	input  wire                  wb_stb_i,
	input  wire                  wb_we_i,
	input  wire [15:0]           wb_adr_i,
	input  wire [3:0]            wb_sel_i,
	input  wire [31:0]           wb_dat_i,
	output reg  [31:0]           wb_dat_o,
	output reg                   wb_ack_o,
	input  wire                  power_cycle_i,
	input  wire                  io_refresh_i,
	input  wire [3:0]            module0_terminal_i,
	input  wire [3:0]            module1_terminal_i,
	input  wire [2*NUM_NORMAL-1:0] normal_pin_i,
	output reg  [2*NUM_NORMAL-1:0] normal_o,
	output reg  [7:0]            normal_fast_o,
	output reg  [7:0]            intr_in_o,
	output reg  [3:0]            cnt_index_o,
	output reg  [3:0]            origin_o,
	output reg  [3:0]            origin_prox_o
);
	// ----------------------------------------
	// configuration: pending and active
	// ----------------------------------------
	reg  [23:0] cfg_pend_reg;
	reg  [23:0] cfg_act_reg;
	reg         pc_s1_reg;
	reg         pc_s2_reg;
	reg         pc_prev_reg;
	reg         ref_s1_reg;
	reg         ref_s2_reg;
	reg         ref_prev_reg;
	reg  [2*NUM_NORMAL-1:0] nrm_s1_reg;
	reg  [2*NUM_NORMAL-1:0] nrm_s2_reg;
	wire [7:0]  pins;
	wire [7:0]  lvl;
	wire [7:0]  cap;
	wire [7:0]  fast_en;
	wire        refresh;
	wire        pc_rise;
	wire        wb_req;
	wire [7:0]  sel_normal;
	wire [7:0]  sel_intr;
	wire [7:0]  sel_origin;
	reg  [31:0] rd_word;

	function [2:0] fn_of;
		input [23:0] cfg;
		input integer k;
		begin
			fn_of = cfg[3*k +: 3];
		end
	endfunction

	function is_fn;
		input [23:0] cfg;
		input integer k;
		input [2:0]  code;
		begin
			is_fn = (fn_of(cfg, k) == code);
		end
	endfunction

	assign pins    = {module1_terminal_i, module0_terminal_i};
	assign refresh = ref_s2_reg & ~ref_prev_reg;
	assign pc_rise = pc_s2_reg & ~pc_prev_reg;
	assign wb_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;

	// ----------------------------------------
	// per-terminal capture cells
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1) begin : g_cell
			// (RULE5) fast capture only when selected
			assign fast_en[g] = is_fn(cfg_act_reg, g, `PLI_FN_FAST);
			// each terminal decodes its own 3-bit field
			assign sel_normal[g] = is_fn(cfg_act_reg, g, `PLI_FN_NORMAL);
			assign sel_intr[g]   = is_fn(cfg_act_reg, g, `PLI_FN_INTR);
			assign sel_origin[g] = is_fn(cfg_act_reg, g, `PLI_FN_ORIGIN);
			pli_capture_cell u_cell (
				.clk_i     (clk_i),
				.rst_i     (rst_i),
				.pin_i     (pins[g]),
				.fast_en_i (fast_en[g]),
				.refresh_i (refresh),
				.level_o   (lvl[g]),
				.bit_o     (cap[g])
			);
		end
	endgenerate

	// ----------------------------------------
	// synchronisers
	// ----------------------------------------
	// restart and refresh are async levels; only their synced edges act
	always @(posedge clk_i) begin
		if (rst_i) begin
			pc_s1_reg    <= 1'b0;
			pc_s2_reg    <= 1'b0;
			pc_prev_reg  <= 1'b0;
			ref_s1_reg   <= 1'b0;
			ref_s2_reg   <= 1'b0;
			ref_prev_reg <= 1'b0;
			nrm_s1_reg   <= {2*NUM_NORMAL{1'b0}};
			nrm_s2_reg   <= {2*NUM_NORMAL{1'b0}};
		end else begin
			pc_s1_reg    <= power_cycle_i;
			pc_s2_reg    <= pc_s1_reg;
			pc_prev_reg  <= pc_s2_reg;
			ref_s1_reg   <= io_refresh_i;
			ref_s2_reg   <= ref_s1_reg;
			ref_prev_reg <= ref_s2_reg;
			nrm_s1_reg   <= normal_pin_i;
			nrm_s2_reg   <= nrm_s1_reg;
		end
	end

	// ----------------------------------------
	// active configuration
	// ----------------------------------------
	// held until a restart, so a scan never sees a half-changed map
	always @(posedge clk_i) begin
		if (rst_i) begin
			cfg_act_reg <= `PLI_CFG_RESET;
		end else begin
			// (RULE4) pending config takes effect on power cycle
			if (pc_rise)
				cfg_act_reg <= cfg_pend_reg;
		end
	end

	// ----------------------------------------
	// function routing
	// ----------------------------------------
	// terminal levels pass through one register stage; normal pins are sampled at refresh; only fast terminals stretch pulses
	integer k;
	always @(posedge clk_i) begin
		if (rst_i) begin
			normal_o      <= {2*NUM_NORMAL{1'b0}};
			normal_fast_o <= 8'h00;
			intr_in_o     <= 8'h00;
			cnt_index_o   <= 4'h0;
			origin_o      <= 4'h0;
			origin_prox_o <= 4'h0;
		end else begin
			// (RULE2) remaining terminals are plain sampled inputs
			if (refresh)
				normal_o <= nrm_s2_reg;
			for (k = 0; k < 8; k = k + 1) begin
				// (RULE5) one function per terminal
				normal_fast_o[k] <= lvl[k] & sel_normal[k];
				intr_in_o[k]     <= lvl[k] & sel_intr[k];
			end
			// (RULE6) terminals 2,3,6,7 feed counters 1,0,3,2
			cnt_index_o[1] <= lvl[2] & is_fn(cfg_act_reg, 2, `PLI_FN_CNT_INDEX);
			cnt_index_o[0] <= lvl[3] & is_fn(cfg_act_reg, 3, `PLI_FN_CNT_INDEX);
			cnt_index_o[3] <= lvl[6] & is_fn(cfg_act_reg, 6, `PLI_FN_CNT_INDEX);
			cnt_index_o[2] <= lvl[7] & is_fn(cfg_act_reg, 7, `PLI_FN_CNT_INDEX);
			for (k = 0; k < 4; k = k + 1) begin
				// (RULE7) even terminal origin, odd proximity
				origin_o[k]      <= lvl[2*k] & sel_origin[2*k];
				origin_prox_o[k] <= lvl[2*k+1] & sel_origin[2*k+1];
			end
		end
	end

	// ----------------------------------------
	// pending configuration
	// ----------------------------------------
	// lane 3 has no field behind it and is dropped
	always @(posedge clk_i) begin
		if (rst_i) begin
			cfg_pend_reg <= `PLI_CFG_RESET;
		end else if (wb_req && wb_we_i && wb_adr_i[15:2] == `PLI_IDX_CFG) begin
			if (wb_sel_i[0])
				cfg_pend_reg[7:0] <= wb_dat_i[7:0];
			if (wb_sel_i[1])
				cfg_pend_reg[15:8] <= wb_dat_i[15:8];
			if (wb_sel_i[2])
				cfg_pend_reg[23:16] <= wb_dat_i[23:16];
		end
	end

	// ----------------------------------------
	// read data select
	// ----------------------------------------
	always @* begin
		rd_word = 32'h00000000;
		case (wb_adr_i[15:2])
		// (RULE3) module0 in bits 0-3
		`PLI_IDX_BITS0:   rd_word = {28'h0000000, cap[3:0]};
		// (RULE3) module1 in bits 0-3
		`PLI_IDX_BITS1:   rd_word = {28'h0000000, cap[7:4]};
		`PLI_IDX_CFG:     rd_word = {8'h00, cfg_pend_reg};
		`PLI_IDX_CFG_ACT: rd_word = {8'h00, cfg_act_reg};
		default:          rd_word = 32'h00000000;
		endcase
	end

	// ----------------------------------------
	// wishbone slave, one-cycle ack
	// ----------------------------------------
	// ack only from idle, so a held request is answered again every other cycle;
	// read data stands for the ack cycle only
	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= wb_req;
			if (wb_req && !wb_we_i)
				wb_dat_o <= rd_word;
			else
				wb_dat_o <= 32'h00000000;
		end
	end
endmodule // pli_pulse_latch_inputs

// >>> inc/pli_consts.vh
// constants and register map of the pulse latch input block
// Contract
// (RULE1) fast-capture terminals register every ON pulse of 30 us or longer.
// (RULE2) only the first four inputs of each module offer fast capture.
// (RULE3) module0 fast states in bits 0-3 of one word, module1 in another.
// (RULE4) new fast-capture configuration applies only after power cycle.
// (RULE5) each shared terminal serves exactly one function; fast capture disables others.
// (RULE6) fast inputs 2,3,6,7 share terminals with counter 1,0,3,2 index/reset.
// (RULE7) even fast input carries origin, odd carries origin-proximity, pulse outputs 0-3.
// (RULE8) pulse shorter than scan cycle held and stored in its bit within one cycle.
// (RULE9) stored ON state of short pulse cleared at following I/O refresh.
// (RULE10) synchronise, latch on rising edge, copy at refresh, clear unless still ON.
`ifndef PLI_CONSTS_VH
`define PLI_CONSTS_VH

// ----------------------------------------
// register map, byte addresses (index * 4)
// ----------------------------------------
`define PLI_IDX_BITS0     14'h0b90
`define PLI_IDX_BITS1     14'h0b92
`define PLI_IDX_CFG       14'h0b94
`define PLI_IDX_CFG_ACT   14'h0b95
`define PLI_IDX_ROUTE     14'h0b96
`define PLI_ADDR_BITS0    16'h2e40
`define PLI_ADDR_BITS1    16'h2e48
`define PLI_ADDR_CFG      16'h2e50
`define PLI_ADDR_CFG_ACT  16'h2e54
`define PLI_ADDR_ROUTE    16'h2e58

// ----------------------------------------
// function codes per terminal (3 bits each)
// ----------------------------------------
`define PLI_FN_NORMAL     3'h0
`define PLI_FN_FAST       3'h1
`define PLI_FN_INTR       3'h2
`define PLI_FN_CNT_INDEX  3'h3
`define PLI_FN_ORIGIN     3'h4
`define PLI_CFG_RESET     24'h000000

// ----------------------------------------
// timing
// ----------------------------------------
`define PLI_MIN_PULSE_NS  30000
`define PLI_CLK_NS        4
`define PLI_MIN_PULSE_CYC ((`PLI_MIN_PULSE_NS + `PLI_CLK_NS - 1) / `PLI_CLK_NS)

`endif

// >>> design/pli_capture_cell.v
// one fast-capture terminal: synchroniser, sticky latch, refresh copy
`timescale 1ns/1ps
module pli_capture_cell (
	input  wire clk_i,
	input  wire rst_i,
	input  wire pin_i,
	input  wire fast_en_i,
	input  wire refresh_i,
	output wire level_o,
	output reg  bit_o
);
	reg sync1_reg;
	reg sync2_reg;
	reg prev_reg;
	reg sticky_reg;
	wire rise;

	assign level_o = sync2_reg;
	assign rise    = sync2_reg & ~prev_reg;

	always @(posedge clk_i) begin
		if (rst_i) begin
			sync1_reg  <= 1'b0;
			sync2_reg  <= 1'b0;
			prev_reg   <= 1'b0;
			sticky_reg <= 1'b0;
			bit_o      <= 1'b0;
		end else begin
			// (RULE10) two-stage synchroniser
			sync1_reg <= pin_i;
			sync2_reg <= sync1_reg;
			prev_reg  <= sync2_reg;
			// (RULE1) edge sets latch; 30 us spans thousands of clocks
			if (!fast_en_i)
				sticky_reg <= 1'b0;
			else if (rise)
				sticky_reg <= 1'b1;
			else if (refresh_i)
				sticky_reg <= 1'b0;
			// (RULE8) latched pulse lands at refresh
			// (RULE9) cleared at next refresh unless still ON
			if (refresh_i)
				bit_o <= fast_en_i & (sticky_reg | rise | sync2_reg);
		end
	end
endmodule // pli_capture_cell

// >>> sim/pli_sensor_model.sv
// sensor model: short pulses onto the eight capture terminals
`timescale 1ns/1ps
module pli_sensor_model (
	input  wire        clk_i,
	input  wire [7:0]  fire_i,
	input  wire [15:0] width_i,
	output reg  [7:0]  pin_o
);
	reg [15:0] left_reg = 16'h0000;
	initial pin_o = 8'h00;
	always @(posedge clk_i) begin
		if (fire_i != 8'h00) begin
			pin_o <= fire_i;
			left_reg <= width_i - 16'h0001;
		end else if (left_reg != 16'h0000) begin
			left_reg <= left_reg - 16'h0001;
		end else begin
			pin_o <= 8'h00;
		end
	end
endmodule // pli_sensor_model

// >>> sim/pli_pulse_latch_inputs_asserts.sv
// port checker for the pulse latch input block
`timescale 1ns/1ps
module pli_pulse_latch_inputs_asserts (
	input wire        clk_i,
	input wire        rst_i,
	input wire        wb_cyc_i,
	input wire        wb_stb_i,
	input wire [15:0] wb_adr_i,
	input wire [31:0] wb_dat_o,
	input wire        wb_ack_o,
	input wire [7:0]  normal_fast_o,
	input wire [7:0]  intr_in_o,
	input wire [3:0]  cnt_index_o,
	input wire [3:0]  origin_o,
	input wire [3:0]  origin_prox_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
	ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("no ack");
	word0_layout_a: assert property (wb_ack_o && wb_adr_i == 16'h2e40 |->
		wb_dat_o[31:4] == 28'h0) else $error("word0 upper bits");
	word1_layout_a: assert property (wb_ack_o && wb_adr_i == 16'h2e48 |->
		wb_dat_o[31:4] == 28'h0) else $error("word1 upper bits");
	fn_exclusive_a: assert property ((normal_fast_o & intr_in_o) == 8'h00)
		else $error("two functions");
	cnt_share_a: assert property (cnt_index_o[1] |->
		!normal_fast_o[2] && !intr_in_o[2] && !origin_o[1]) else $error("index shared");
	origin_pair_a: assert property ((origin_o & {normal_fast_o[6],
		normal_fast_o[4], normal_fast_o[2], normal_fast_o[0]}) == 4'h0) else $error("origin");
	prox_pair_a: assert property ((origin_prox_o & {intr_in_o[7],
		intr_in_o[5], intr_in_o[3], intr_in_o[1]}) == 4'h0) else $error("proximity");
	cover property (wb_ack_o && wb_adr_i == 16'h2e40 && wb_dat_o[0]);
	cover property (cnt_index_o[1]);
	cover property (origin_o[0] && origin_prox_o[0]);
endmodule // pli_pulse_latch_inputs_asserts
bind pli_pulse_latch_inputs pli_pulse_latch_inputs_asserts i_pli_pulse_latch_inputs_asserts (
	.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.normal_fast_o(normal_fast_o), .intr_in_o(intr_in_o), .cnt_index_o(cnt_index_o),
	.origin_o(origin_o), .origin_prox_o(origin_prox_o));

// >>> sim/pli_pulse_latch_inputs_tb.sv
// bench for the pulse latch input block
`timescale 1ns/1ps
module pli_pulse_latch_inputs_tb;
	reg         clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, pwr = 0, rfr = 0;
	reg  [15:0] adr = 0, wid = 0;
	reg  [31:0] dat = 0, q;
	reg  [11:0] npin = 0;
	reg  [7:0]  fire = 0;
	wire [7:0]  pin, nf, ii;
	wire [31:0] rd;
	wire [11:0] no;
	wire [3:0]  ci, oo, op;
	wire        ack;
	integer     mismatches = 0, num_checks = 0;
	pli_sensor_model i_pli_sensor_model (.clk_i(clk_i), .fire_i(fire), .width_i(wid),
		.pin_o(pin));
	pli_pulse_latch_inputs i_pli_pulse_latch_inputs (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
		.wb_dat_i(dat), .wb_dat_o(rd), .wb_ack_o(ack), .power_cycle_i(pwr),
		.io_refresh_i(rfr), .module0_terminal_i(pin[3:0]), .module1_terminal_i(pin[7:4]),
		.normal_pin_i(npin), .normal_o(no), .normal_fast_o(nf), .intr_in_o(ii),
		.cnt_index_o(ci), .origin_o(oo), .origin_prox_o(op));
	initial forever #2 clk_i = ~clk_i;
	task end_sim; begin
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	end endtask
	task cmp(input [31:0] got, input [31:0] exp); begin
		num_checks = num_checks + 1;
		if (got !== exp) begin
			mismatches = mismatches + 1;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	end endtask
	// one classic cycle, held until ack is sampled
	task wb(input [15:0] a, input w, input [31:0] d); integer n; begin
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		dat <= d;
		n = 0;
		@(posedge clk_i);
		while (ack !== 1'b1 && n < 50) begin
			n = n + 1;
			@(posedge clk_i);
		end
		q = rd;
		cyc <= 0;
		stb <= 0;
		we <= 0;
		@(posedge clk_i);
	end endtask
	task chk_rd(input [15:0] a, input [31:0] exp); begin
		wb(a, 1'b0, 32'h0);
		cmp(q, exp);
	end endtask
	// power restart when p, else one i/o refresh
	task strobe(input p); begin
		if (p) pwr <= 1;
		else rfr <= 1;
		repeat (6) @(posedge clk_i);
		pwr <= 0;
		rfr <= 0;
		repeat (4) @(posedge clk_i);
	end endtask
	task pulse(input [7:0] m, input [15:0] w, input [15:0] t); begin
		fire <= m;
		wid <= w;
		@(posedge clk_i);
		fire <= 0;
		repeat (t) @(posedge clk_i);
	end endtask
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
		chk_rd(16'h2e50, 32'h0);
		wb(16'h2e50, 1'b1, 32'h00249249);
		wb(16'h2e54, 1'b1, 32'h00ffffff);
		chk_rd(16'h2e54, 32'h0);
		chk_rd(16'h2e60, 32'h0);
		pulse(8'hff, 16'h1d4c, 16'h1d5c);
		strobe(0);
		chk_rd(16'h2e40, 32'h0);
		strobe(1);
		chk_rd(16'h2e54, 32'h00249249);
		pulse(8'ha5, 16'h1d4c, 16'h1d5c);
		strobe(0);
		chk_rd(16'h2e40, 32'h5);
		chk_rd(16'h2e48, 32'ha);
		strobe(0);
		chk_rd(16'h2e40, 32'h0);
		pulse(8'h02, 16'h0064, 16'h0014);
		strobe(0);
		chk_rd(16'h2e40, 32'h2);
		strobe(0);
		chk_rd(16'h2e40, 32'h2);
		repeat (80) @(posedge clk_i);
		strobe(0);
		chk_rd(16'h2e40, 32'h0);
		wb(16'h2e50, 1'b1, 32'h000020e4);
		strobe(1);
		npin <= 12'h5a3;
		pulse(8'hff, 16'h00c8, 16'h0014);
		cmp(ci, 32'h2);
		cmp(oo, 32'h1);
		cmp(op, 32'h1);
		cmp(ii, 32'h10);
		cmp(nf, 32'he8);
		strobe(0);
		cmp(no, 32'h5a3);
		end_sim;
	end
	initial begin
		#200000;
		mismatches = mismatches + 1;
		end_sim;
	end
endmodule // pli_pulse_latch_inputs_tb
